// ===== common/arsc_pkg.sv
package arsc_pkg;

   localparam int N_BLK    = 7;
   localparam int N_LINE   = 6;
   localparam int MAX_SHOT = 5;

   // Timebase: one tick per millisecond
   localparam int CLK_NS   = 10;
   localparam int TICK_NS  = 1000000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STAT     = 8'h04;
   localparam logic [7:0] OFS_CMD      = 8'h08;
   localparam logic [7:0] OFS_RECLAIM  = 8'h0c;
   localparam logic [7:0] OFS_AUTOWAIT = 8'h10;
   localparam logic [7:0] OFS_WCLOSE   = 8'h14;
   localparam logic [7:0] OFS_BLK0     = 8'h20;
   localparam logic [7:0] OFS_BLK_END  = 8'h58;

   // Control fields
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_SKIP_BIT  = 1;
   localparam int CTRL_COND_LSB  = 2;
   localparam int CTRL_AMASK_LSB = 4;
   localparam int COND_SYNC_BIT  = 0;
   localparam int COND_CB_BIT    = 1;

   // Status fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_PTR_LSB   = 4;
   localparam int STAT_BLK_LSB   = 8;
   localparam int STAT_SUCC_BIT  = 12;
   localparam int STAT_COF_BIT   = 13;
   localparam int STAT_LOCK_BIT  = 14;

   // Command fields
   localparam int CMD_RELEASE_BIT  = 0;
   localparam int CMD_SUCC_CLR_BIT = 1;

   // Shot block configuration word fields
   localparam int CFG_INIT_LSB = 0;
   localparam int CFG_BLK_LSB  = 8;
   localparam int CFG_SHOT_LSB = 16;

   // Reset values, times in ticks
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [15:0] RECLAIM_RST  = 16'h2710;
   localparam logic [15:0] AUTOWAIT_RST = 16'h07d0;
   localparam logic [15:0] WCLOSE_RST   = 16'h00c8;
   localparam logic [15:0] DELAY_RST    = 16'h03e8;

   typedef enum logic [2:0] {
      S_IDLE,
      S_DEAD,
      S_SYNC,
      S_CLOSE,
      S_RECLAIM,
      S_LOCK
   } arsc_state_t;

endpackage

// ===== common/arsc_sel_if.sv
`timescale 1ns/1ps
`default_nettype none
interface arsc_sel_if;
   import arsc_pkg::*;
   logic [N_LINE-1:0] lines;
   logic [2:0]        ptr;
   logic              skip;
   logic [N_LINE-1:0] init_mask [N_BLK];
   logic [N_LINE-1:0] blk_mask  [N_BLK];
   logic [2:0]        shot_idx  [N_BLK];
   logic              sel_any;
   logic [2:0]        sel_idx;
   logic              blocked;

   modport top (output lines, ptr, skip, init_mask, blk_mask, shot_idx,
                input sel_any, sel_idx, blocked);
   modport sel (input lines, ptr, skip, init_mask, blk_mask, shot_idx,
                output sel_any, sel_idx, blocked);
endinterface
`default_nettype wire

// ===== hw/arsc_shot_sel.sv
`timescale 1ns/1ps
`default_nettype none
module arsc_shot_sel
   import arsc_pkg::*;
(
   arsc_sel_if.sel s
);

   always_comb begin
      s.sel_any = 1'b0;
      s.sel_idx = 3'h0;
      s.blocked = 1'b0;
      // Downward walk so the lowest block number wins
      for (int i = N_BLK - 1; i >= 0; i--) begin
         if (|(s.init_mask[i] & s.lines)) begin
            if (|(s.blk_mask[i] & s.lines)) begin
               s.blocked = 1'b1;
            end
            if (s.shot_idx[i] != 3'h0 && s.shot_idx[i] <= 3'(MAX_SHOT) &&
                (s.skip ? (s.shot_idx[i] > s.ptr)
                        : (s.shot_idx[i] == s.ptr + 3'h1))) begin
               s.sel_any = 1'b1;
               s.sel_idx = 3'(i);
            end
         end
      end
   end

endmodule
`default_nettype wire

// ===== hw/arsc_top.sv
// Functional notes
// - Seven identical shot blocks, each fully configurable
// - Block reclose delay sets open-to-close dead time
// - Initiation mask: line n has weight 2^(n-1)
// - Blocking mask uses the same line weights
// - Shot index names shot one to five
// - All blocks evaluated in parallel at initiation
// - Active blocking line at start forces lockout
// - Shot pointer limits eligibility to later shots
// - Without skip, only next-shot blocks accepted
// - With skip, next or later shots accepted
// - Lowest numbered eligible block wins
// - At most five shots per sequence
// - No eligible block means lockout
// - Several lines: any match continues, else lockout
// - Four automatic initiation condition choices
// - Sync failure auto-starts after auto wait
// - Breaker not closed after wait auto-starts
// - Auto line mask resets to zero, disabling
// - Auto continuation only for shots two to five
// - Close only after delay with sync ok
// - Breaker closed starts reclaim; expiry means success
// - Uncommanded close prohibits initiation from idle for reclaim
`timescale 1ns/1ps
`default_nettype none
module arsc_top
   import arsc_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYC
)
(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire logic [N_LINE-1:0] init_line,
   input  wire logic              breaker_closed,
   input  wire logic              sync_ok,
   output logic                   breaker_open_cmd,
   output logic                   breaker_close_cmd,
   output logic                   lockout,
   output logic                   close_onto_fault
);

   arsc_sel_if sif ();

   logic [N_LINE-1:0] init_m;
   logic [N_LINE-1:0] init_s;
   logic              brk_m;
   logic              brk_s;
   logic              brk_q;
   logic              syn_m;
   logic              syn_s;

   logic [16:0]       div_cnt;
   logic              tick;

   logic              ctrl_en;
   logic              skip;
   logic [1:0]        cond;
   logic [N_LINE-1:0] amask;
   logic [15:0]       reclaim_t;
   logic [15:0]       autowait_t;
   logic [15:0]       wclose_t;
   logic [N_LINE-1:0] blk_init  [N_BLK];
   logic [N_LINE-1:0] blk_blk   [N_BLK];
   logic [2:0]        blk_shot  [N_BLK];
   logic [15:0]       blk_delay [N_BLK];

   logic              dp_valid;
   logic              dp_write;
   logic [7:0]        dp_addr;
   logic              ap_take;
   logic [31:0]       rd_val;
   logic              wr_cmd;

   arsc_state_t       state;
   arsc_state_t       next_state;
   logic [2:0]        ptr;
   logic [2:0]        cur_blk;
   logic [15:0]       tmr;
   logic              tmr_exp;
   logic              do_start;
   logic [N_LINE-1:0] start_lines;
   logic              auto_ok;
   logic              succ;
   logic              reclaim_done;
   logic [15:0]       cof_cnt;
   logic              cof_evt;

   // Block number from a byte address inside the block area
   function automatic logic [2:0] blk_of(input logic [7:0] a);
      logic [7:0] d;
      d = a - OFS_BLK0;
      return d[5:3];
   endfunction

   function automatic logic in_blk(input logic [7:0] a);
      return (a >= OFS_BLK0) && (a < OFS_BLK_END);
   endfunction

   // Pins come from the breaker yard and the protection side
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_m <= '0;
         init_s <= '0;
         brk_m  <= 1'b0;
         brk_s  <= 1'b0;
         brk_q  <= 1'b0;
         syn_m  <= 1'b0;
         syn_s  <= 1'b0;
      end else begin
         init_m <= init_line;
         init_s <= init_m;
         brk_m  <= breaker_closed;
         brk_s  <= brk_m;
         brk_q  <= brk_s;
         syn_m  <= sync_ok;
         syn_s  <= syn_m;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt <= '0;
         tick    <= 1'b0;
      end else if (div_cnt == 17'(TICK_DIV - 1)) begin
         div_cnt <= '0;
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 17'h1;
         tick    <= 1'b0;
      end
   end

   // Zero wait states, so hreadyout never stalls the master
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign ap_take   = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr  <= 8'h00;
      end else if (hready) begin
         dp_valid <= ap_take && (haddr[31:8] == 24'h0);
         dp_write <= hwrite;
         dp_addr  <= haddr[7:0];
      end
   end

   always_comb begin
      rd_val = 32'h0;
      if (haddr[31:8] != 24'h0) begin
         rd_val = 32'h0;
      end else if (haddr[7:0] == OFS_CTRL) begin
         rd_val[CTRL_EN_BIT]                    = ctrl_en;
         rd_val[CTRL_SKIP_BIT]                  = skip;
         rd_val[CTRL_COND_LSB +: 2]             = cond;
         rd_val[CTRL_AMASK_LSB +: N_LINE]       = amask;
      end else if (haddr[7:0] == OFS_STAT) begin
         rd_val[STAT_STATE_LSB +: 3]            = state;
         rd_val[STAT_PTR_LSB +: 3]              = ptr;
         rd_val[STAT_BLK_LSB +: 3]              = cur_blk;
         rd_val[STAT_SUCC_BIT]                  = succ;
         rd_val[STAT_COF_BIT]                   = close_onto_fault;
         rd_val[STAT_LOCK_BIT]                  = lockout;
      end else if (haddr[7:0] == OFS_RECLAIM) begin
         rd_val[15:0] = reclaim_t;
      end else if (haddr[7:0] == OFS_AUTOWAIT) begin
         rd_val[15:0] = autowait_t;
      end else if (haddr[7:0] == OFS_WCLOSE) begin
         rd_val[15:0] = wclose_t;
      end else if (in_blk(haddr[7:0]) && haddr[2]) begin
         rd_val[15:0] = blk_delay[blk_of(haddr[7:0])];
      end else if (in_blk(haddr[7:0]) && haddr[1:0] == 2'h0) begin
         rd_val[CFG_INIT_LSB +: N_LINE] = blk_init[blk_of(haddr[7:0])];
         rd_val[CFG_BLK_LSB +: N_LINE]  = blk_blk[blk_of(haddr[7:0])];
         rd_val[CFG_SHOT_LSB +: 3]      = blk_shot[blk_of(haddr[7:0])];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (ap_take && !hwrite) begin
         hrdata <= rd_val;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_en    <= CTRL_RST[CTRL_EN_BIT];
         skip       <= CTRL_RST[CTRL_SKIP_BIT];
         cond       <= CTRL_RST[CTRL_COND_LSB +: 2];
         amask      <= CTRL_RST[CTRL_AMASK_LSB +: N_LINE];
         reclaim_t  <= RECLAIM_RST;
         autowait_t <= AUTOWAIT_RST;
         wclose_t   <= WCLOSE_RST;
      end else if (dp_valid && dp_write) begin
         if (dp_addr == OFS_CTRL) begin
            ctrl_en <= hwdata[CTRL_EN_BIT];
            skip    <= hwdata[CTRL_SKIP_BIT];
            cond    <= hwdata[CTRL_COND_LSB +: 2];
            amask   <= hwdata[CTRL_AMASK_LSB +: N_LINE];
         end else if (dp_addr == OFS_RECLAIM) begin
            reclaim_t <= hwdata[15:0];
         end else if (dp_addr == OFS_AUTOWAIT) begin
            autowait_t <= hwdata[15:0];
         end else if (dp_addr == OFS_WCLOSE) begin
            wclose_t <= hwdata[15:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < N_BLK; i++) begin
            blk_init[i]  <= '0;
            blk_blk[i]   <= '0;
            blk_shot[i]  <= 3'h0;
            blk_delay[i] <= DELAY_RST;
         end
      end else if (dp_valid && dp_write && in_blk(dp_addr)) begin
         if (dp_addr[2]) begin
            blk_delay[blk_of(dp_addr)] <= hwdata[15:0];
         end else if (dp_addr[1:0] == 2'h0) begin
            blk_init[blk_of(dp_addr)] <= hwdata[CFG_INIT_LSB +: N_LINE];
            blk_blk[blk_of(dp_addr)]  <= hwdata[CFG_BLK_LSB +: N_LINE];
            blk_shot[blk_of(dp_addr)] <= hwdata[CFG_SHOT_LSB +: 3];
         end
      end
   end

   assign wr_cmd = dp_valid && dp_write && (dp_addr == OFS_CMD);

   assign sif.lines     = start_lines;
   assign sif.ptr       = ptr;
   assign sif.skip      = skip;
   assign sif.init_mask = blk_init;
   assign sif.blk_mask  = blk_blk;
   assign sif.shot_idx  = blk_shot;

   arsc_shot_sel u_sel (
      .s (sif.sel)
   );

   assign tmr_exp      = tick && (tmr == 16'h0);
   assign auto_ok      = (ptr != 3'h0) && (ptr < 3'(MAX_SHOT));
   // Only automatic starts happen in these two phases, so there the selector sees the auto line mask
   assign start_lines  = (state == S_SYNC || state == S_CLOSE) ? amask : init_s;
   assign reclaim_done = (state == S_RECLAIM) && tmr_exp && !(|init_s);

   always_comb begin
      next_state  = state;
      do_start    = 1'b0;
      case (state)
         S_IDLE: begin
            // The close edge itself already forbids a start, not only the flag after it
            if (ctrl_en && |init_s && !close_onto_fault && !cof_evt) begin
               do_start = 1'b1;
            end
         end
         S_DEAD: begin
            if (tmr_exp) begin
               next_state = syn_s ? S_CLOSE : S_SYNC;
            end
         end
         S_SYNC: begin
            if (syn_s) begin
               next_state = S_CLOSE;
            end else if (tmr_exp) begin
               if (cond[COND_SYNC_BIT] && auto_ok) begin
                  do_start    = 1'b1;
               end else begin
                  next_state = S_LOCK;
               end
            end
         end
         S_CLOSE: begin
            if (brk_s) begin
               next_state = S_RECLAIM;
            end else if (tmr_exp) begin
               if (cond[COND_CB_BIT] && auto_ok) begin
                  do_start    = 1'b1;
               end else begin
                  next_state = S_LOCK;
               end
            end
         end
         S_RECLAIM: begin
            if (|init_s) begin
               do_start = 1'b1;
            end else if (tmr_exp) begin
               next_state = S_IDLE;
            end
         end
         S_LOCK: begin
            if (wr_cmd && hwdata[CMD_RELEASE_BIT]) begin
               next_state = S_IDLE;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
      if (do_start) begin
         // Blocking or no eligible block ends the sequence
         next_state = (sif.blocked || !sif.sel_any) ? S_LOCK : S_DEAD;
      end
      if (!ctrl_en) begin
         next_state = S_IDLE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ptr     <= 3'h0;
         cur_blk <= 3'h0;
      end else if (next_state == S_IDLE) begin
         ptr <= 3'h0;
      end else if (do_start && next_state == S_DEAD) begin
         ptr     <= blk_shot[sif.sel_idx];
         cur_blk <= sif.sel_idx;
      end
   end

   // Each phase reloads the shared timer on entry
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tmr <= 16'h0;
      end else if (next_state != state || do_start) begin
         case (next_state)
            S_DEAD:    tmr <= blk_delay[sif.sel_idx];
            S_SYNC:    tmr <= autowait_t;
            S_CLOSE:   tmr <= wclose_t;
            S_RECLAIM: tmr <= reclaim_t;
            default:   tmr <= 16'h0;
         endcase
      end else if (tick && tmr != 16'h0) begin
         tmr <= tmr - 16'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         succ <= 1'b0;
      end else if (reclaim_done) begin
         succ <= 1'b1;
      end else if (wr_cmd && hwdata[CMD_SUCC_CLR_BIT]) begin
         succ <= 1'b0;
      end
   end

   // A close seen outside our own close phase was not ours
   assign cof_evt = brk_s && !brk_q && (state != S_CLOSE);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cof_cnt          <= 16'h0;
         close_onto_fault <= 1'b0;
      end else if (cof_evt) begin
         cof_cnt          <= reclaim_t;
         close_onto_fault <= 1'b1;
      end else if (tick && close_onto_fault) begin
         if (cof_cnt == 16'h0) begin
            close_onto_fault <= 1'b0;
         end else begin
            cof_cnt <= cof_cnt - 16'h1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         breaker_open_cmd  <= 1'b0;
         breaker_close_cmd <= 1'b0;
         lockout           <= 1'b0;
      end else begin
         breaker_open_cmd  <= (next_state == S_DEAD) || (next_state == S_SYNC);
         breaker_close_cmd <= (next_state == S_CLOSE);
         lockout           <= (next_state == S_LOCK);
      end
   end

endmodule
`default_nettype wire

// ===== tb/arsc_cb_model.sv
`timescale 1ns/1ps
`default_nettype none
module arsc_cb_model (
   input  wire logic hclk,
   input  wire logic open_cmd,
   input  wire logic close_cmd,
   input  wire logic fail_close,
   input  wire logic man_open,
   input  wire logic man_close,
   output logic      closed
);
   logic [1:0] cnt;
   initial begin
      closed = 1'b0;
      cnt = 2'd0;
   end
   // Mechanism takes a few cycles; a stuck drive never closes
   always @(posedge hclk) begin
      cnt <= (close_cmd && !fail_close) ? cnt + 2'd1 : 2'd0;
      if (open_cmd || man_open)
         closed <= 1'b0;
      else if (man_close || cnt == 2'd3)
         closed <= 1'b1;
   end
endmodule
`default_nettype wire

// ===== tb/arsc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module arsc_top_sva
   import arsc_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYC
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic sync_ok,
   input wire logic breaker_open_cmd,
   input wire logic breaker_close_cmd,
   input wire logic lockout,
   input wire logic close_onto_fault
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_cmd_exclusive: assert property (!(breaker_open_cmd && breaker_close_cmd))
      else $error("open and close both high");
   a_close_after_open: assert property ($rose(breaker_close_cmd) |->
      $past(breaker_open_cmd)) else $error("close without dead interval");
   // Sync input crosses two flops before the state logic sees it
   a_close_sync_ok: assert property ($rose(breaker_close_cmd) |->
      ($past(sync_ok, 2) || $past(sync_ok, 3) || $past(sync_ok, 4)))
      else $error("close without sync");
   a_dead_min: assert property ($rose(breaker_open_cmd) |-> breaker_open_cmd[*4])
      else $error("dead interval shorter than one tick");
   a_close_bounded: assert property ($rose(breaker_close_cmd) |->
      ##[1:400] !breaker_close_cmd) else $error("close command hangs");
   a_lock_quiet: assert property (lockout |-> !breaker_open_cmd && !breaker_close_cmd)
      else $error("command in lockout");
   // Only valid while the prohibition starts in idle, as the bench does
   a_cof_blocks: assert property (close_onto_fault[*6] |-> !breaker_open_cmd)
      else $error("shot started during prohibition");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus response not okay");
   a_reset_quiet: assert property ($rose(hresetn) |-> !breaker_open_cmd && !lockout)
      else $error("outputs active after reset");
   c_lock: cover property ($rose(lockout));
   c_close: cover property ($rose(breaker_close_cmd));
   c_cof: cover property ($rose(close_onto_fault));
endmodule
bind arsc_top arsc_top_sva #(.TICK_DIV(TICK_DIV)) u_sva (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .sync_ok(sync_ok), .breaker_open_cmd(breaker_open_cmd),
   .breaker_close_cmd(breaker_close_cmd), .lockout(lockout),
   .close_onto_fault(close_onto_fault));
`default_nettype wire

// ===== tb/arsc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module arsc_top_tb_top;
   import arsc_pkg::*;
   logic              hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0]       haddr, hwdata, hrdata, rd;
   logic [1:0]        htrans;
   logic [2:0]        hsize, cnd;
   logic [N_LINE-1:0] init_line;
   logic              breaker_closed, sync_ok, fail_close, man_open, man_close;
   logic              breaker_open_cmd, breaker_close_cmd, lockout, close_onto_fault;
   logic              f, lk;
   int                bad_count = 0;
   int                checks = 0;
   int                cyc = 0;
   int                open_cyc = 0;
   int                open_last = 0;
   assign hready = hreadyout;
   // Short tick keeps every timer to a few dozen cycles
   arsc_top #(.TICK_DIV(4)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .init_line(init_line), .breaker_closed(breaker_closed), .sync_ok(sync_ok),
      .breaker_open_cmd(breaker_open_cmd), .breaker_close_cmd(breaker_close_cmd),
      .lockout(lockout), .close_onto_fault(close_onto_fault));
   arsc_cb_model cbm (.hclk(hclk), .open_cmd(breaker_open_cmd),
      .close_cmd(breaker_close_cmd), .fail_close(fail_close), .man_open(man_open),
      .man_close(man_close), .closed(breaker_closed));
   always #5 hclk = ~hclk;
   // Length of the last open command, in clock cycles
   always @(posedge hclk) begin
      open_cyc <= breaker_open_cmd ? open_cyc + 1 : 0;
      if (!breaker_open_cmd && open_cyc != 0)
         open_last <= open_cyc;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 50000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] o, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, o};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wait_st(input logic [2:0] st);
      int n;
      n = 0;
      do begin
         ahb(1'b0, OFS_STAT, 32'h0);
         n++;
      end while (rd[2:0] !== st && n < 300);
      chk("state", {29'h0, st}, {29'h0, rd[2:0]});
   endtask
   task automatic trip(input logic [5:0] v, input logic [2:0] st);
      @(posedge hclk);
      init_line <= v;
      wait_st(st);
      @(posedge hclk);
      init_line <= 6'h00;
   endtask
   task automatic cfg(input int n, input logic [5:0] im, input logic [5:0] bm,
                      input logic [2:0] sh);
      ahb(1'b1, OFS_BLK0 + 8'(8 * n), {13'h0, sh, 2'h0, bm, 2'h0, im});
      ahb(1'b1, OFS_BLK0 + 8'(8 * n + 4), 32'h2);
   endtask
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      init_line = 6'h00;
      sync_ok = 1'b1;
      fail_close = 1'b0;
      man_open = 1'b0;
      man_close = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl", CTRL_RST, rd);
      ahb(1'b0, OFS_RECLAIM, 32'h0);
      chk("reclaim", {16'h0, RECLAIM_RST}, rd);
      ahb(1'b0, OFS_BLK0 + 8'h4, 32'h0);
      chk("delay", {16'h0, DELAY_RST}, rd);
      ahb(1'b0, 8'hfc, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("test reset done");
      ahb(1'b1, OFS_RECLAIM, 32'h8);
      ahb(1'b1, OFS_AUTOWAIT, 32'h3);
      ahb(1'b1, OFS_WCLOSE, 32'h3);
      cfg(0, 6'h07, 6'h10, 3'd1);
      cfg(1, 6'h06, 6'h10, 3'd2);
      cfg(2, 6'h04, 6'h10, 3'd3);
      cfg(3, 6'h08, 6'h00, 3'd1);
      cfg(4, 6'h20, 6'h00, 3'd3);
      ahb(1'b1, OFS_CTRL, 32'h1);
      // Lines 3 and 4 together walk shots one to three, then run out
      for (int i = 0; i < 3; i++) begin
         trip(6'h0c, 3'd1);
         chk("block", 32'(i), {29'h0, rd[10:8]});
         wait_st(3'd4);
      end
      trip(6'h0c, 3'd5);
      chk("lockout", 32'h1, {31'h0, lockout});
      ahb(1'b1, OFS_CMD, 32'h1);
      wait_st(3'd0);
      $display("test sequence done");
      trip(6'h08, 3'd1);
      chk("block", 32'h3, {29'h0, rd[10:8]});
      wait_st(3'd4);
      // Delay of 2 ticks of 4 cycles, plus a partial first tick
      chk("dead", 32'h1, {31'h0, open_last >= 9 && open_last <= 12});
      wait_st(3'd0);
      chk("success", 32'h1, {31'h0, rd[STAT_SUCC_BIT]});
      ahb(1'b1, OFS_CMD, 32'h2);
      ahb(1'b0, OFS_STAT, 32'h0);
      chk("success", 32'h0, {31'h0, rd[STAT_SUCC_BIT]});
      $display("test success done");
      @(posedge hclk);
      man_open <= 1'b1;
      @(posedge hclk);
      man_open <= 1'b0;
      man_close <= 1'b1;
      @(posedge hclk);
      man_close <= 1'b0;
      init_line <= 6'h01;
      repeat (6) @(posedge hclk);
      chk("cof", 32'h1, {31'h0, close_onto_fault});
      ahb(1'b0, OFS_STAT, 32'h0);
      chk("state", 32'h0, {29'h0, rd[2:0]});
      trip(6'h01, 3'd1);
      wait_st(3'd4);
      wait_st(3'd0);
      $display("test prohibition done");
      trip(6'h11, 3'd5);
      chk("lockout", 32'h1, {31'h0, lockout});
      ahb(1'b1, OFS_CMD, 32'h1);
      wait_st(3'd0);
      $display("test blocking done");
      for (int s = 0; s < 2; s++) begin
         ahb(1'b1, OFS_CTRL, 32'(1 + 2 * s));
         trip(6'h01, 3'd1);
         wait_st(3'd4);
         trip(6'h20, s ? 3'd1 : 3'd5);
         chk("block", s ? 32'h4 : 32'h0, {29'h0, rd[10:8]});
         ahb(1'b1, OFS_CTRL, 32'h0);
      end
      $display("test skip done");
      // Every condition against both kinds of failure
      for (int i = 0; i < 8; i++) begin
         cnd = 3'(i);
         f = cnd[0];
         lk = f ? !cnd[1] : !cnd[2];
         ahb(1'b1, OFS_CTRL, {22'h0, 6'h04, cnd[2:1], 2'b01});
         sync_ok <= !f;
         fail_close <= !f;
         trip(6'h04, 3'd1);
         wait_st(f ? 3'd2 : 3'd3);
         wait_st(lk ? 3'd5 : 3'd1);
         chk("block", lk ? 32'h0 : 32'h1, {29'h0, rd[10:8]});
         ahb(1'b1, OFS_CTRL, 32'h0);
         sync_ok <= 1'b1;
         fail_close <= 1'b0;
      end
      $display("test auto done");
      print_verdict();
   end
endmodule
`default_nettype wire
